/* lcell_defs.svh */
`ifndef LCELL_DEFS_SVH
`define LCELL_DEFS_SVH
`define LCELL_OFF_CTRL   8'h00
`define LCELL_OFF_POL    8'h04
`define LCELL_OFF_SEL0   8'h08
`define LCELL_OFF_SEL1   8'h0C
`define LCELL_OFF_GATE1  8'h10
`define LCELL_OFF_GATE2  8'h14
`define LCELL_OFF_GATE3  8'h18
`define LCELL_OFF_GATE4  8'h1C
`define LCELL_OFF_MIRROR 8'h20
`define LCELL_OFF_FLAG   8'h24
`define LCELL_RB_BIT     5
`define LCELL_FINV_BIT   7
`define LCELL_FLAG_BIT   0
`define LCELL_CTRL_RST   8'h00
`define LCELL_FINV_RST   1'b0
`define LCELL_HFOSC_IDX  4'hD
`define LCELL_BASE1      4'h0
`define LCELL_BASE2      4'h4
`define LCELL_BASE3      4'h8
`define LCELL_BASE4      4'hC
`endif

/* lcell_pkg.sv */
package lcell_pkg;
	typedef enum logic [2:0] {
		LCELL_AND_OR = 3'h0,
		LCELL_OR_XOR = 3'h1,
		LCELL_AND4   = 3'h2,
		LCELL_SR     = 3'h3,
		LCELL_DFF_SR = 3'h4,
		LCELL_DFF_R  = 3'h5,
		LCELL_JK_R   = 3'h6,
		LCELL_DLAT   = 3'h7
	} lcell_mode_t;
	typedef struct packed {
		logic        cell_on_bit;
		logic        pin_drive_enable;
		logic        output_readback;
		logic        rise_irq_enable;
		logic        fall_irq_enable;
		lcell_mode_t function_select;
	} lcell_ctrl_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
	} lcell_dphase_t;
endpackage

/* lcell_core.sv */
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "lcell_defs.svh"
module lcell_core #(
	parameter int CELLS    = 2,
	parameter int CELL_IDX = 0
) (
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic               hready,
	input  wire logic [31:0]        hwdata,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [15:0]        data_in,
	input  wire logic [CELLS-1:0]   peer_outputs,
	output logic                    cell_out,
	output logic                    pin_out,
	output logic                    pin_oe,
	output logic                    cell_irq_flag,
	output logic                    osc_keep_request
);
	import lcell_pkg::*;

	lcell_dphase_t dp;
	lcell_dphase_t next_dp;
	lcell_ctrl_t   ctrl;
	lcell_ctrl_t   next_ctrl;
	logic          final_output_invert;
	logic          next_finv;
	logic [3:0]    gate_invert;
	logic [3:0]    next_ginv;
	logic [2:0]    sel [4];
	logic [2:0]    next_sel [4];
	logic [7:0]    gsel [4];
	logic [7:0]    next_gsel [4];
	logic          q;
	logic          next_q;
	logic          clk_prev;
	logic          next_out;
	logic          next_flag;
	logic [3:0]    d;
	logic [3:0]    g;
	logic [3:0]    idx;
	logic          func;
	logic          clk_rise;
	logic          rise_evt;
	logic          fall_evt;
	logic          wr;
	logic          flag_clr;
	logic [7:0]    mirror;

	function automatic logic [3:0] src_idx(input logic [2:0] s,
		input logic [3:0] base);
		src_idx = {1'b0, s} + base;
	endfunction

	// and of enabled true/inverted inputs; even bit true, odd bit inverted
	function automatic logic gate_fn(input logic [7:0] m,
		input logic [3:0] x, input logic inv);
		logic a;
		a = |m;
		for (int j = 0; j < 4; j++) begin
			a = a & (~m[2*j] | x[j]) & (~m[2*j+1] | ~x[j]);
		end
		gate_fn = a ^ inv;
	endfunction

	// bus: zero wait state slave, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_comb begin
		next_dp.valid = 1'b0;
		next_dp.write = 1'b0;
		next_dp.addr  = 8'h00;
		if (hsel && hready && htrans[1]) begin
			next_dp.valid = 1'b1;
			next_dp.write = hwrite;
			next_dp.addr  = haddr[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dp <= '0;
		end else begin
			dp <= next_dp;
		end
	end

	assign wr = dp.valid && dp.write;

	// config registers
	always_comb begin
		next_ctrl = ctrl;
		next_finv = final_output_invert;
		next_ginv = gate_invert;
		for (int k = 0; k < 4; k++) begin
			next_sel[k]  = sel[k];
			next_gsel[k] = gsel[k];
		end
		if (wr) begin
			case (dp.addr)
				`LCELL_OFF_CTRL: begin
					next_ctrl = lcell_ctrl_t'(hwdata[7:0]);
					next_ctrl.output_readback = 1'b0;
				end
				`LCELL_OFF_POL: begin
					next_finv = hwdata[`LCELL_FINV_BIT];
					next_ginv = hwdata[3:0];
				end
				`LCELL_OFF_SEL0: begin
					next_sel[0] = hwdata[2:0];
					next_sel[1] = hwdata[6:4];
				end
				`LCELL_OFF_SEL1: begin
					next_sel[2] = hwdata[2:0];
					next_sel[3] = hwdata[6:4];
				end
				`LCELL_OFF_GATE1: next_gsel[0] = hwdata[7:0];
				`LCELL_OFF_GATE2: next_gsel[1] = hwdata[7:0];
				`LCELL_OFF_GATE3: next_gsel[2] = hwdata[7:0];
				`LCELL_OFF_GATE4: next_gsel[3] = hwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl                <= lcell_ctrl_t'(`LCELL_CTRL_RST);
			final_output_invert <= `LCELL_FINV_RST;
		end else begin
			ctrl                <= next_ctrl;
			final_output_invert <= next_finv;
		end
	end

	// selections, gating and gate polarity are kept across reset
	always_ff @(posedge ref_clk) begin
		gate_invert <= next_ginv;
		for (int k = 0; k < 4; k++) begin
			sel[k]  <= next_sel[k];
			gsel[k] <= next_gsel[k];
		end
	end

	// data selection and gating
	always_comb begin
		idx  = 4'h0;
		d[0] = data_in[src_idx(sel[0], `LCELL_BASE1)];
		d[1] = data_in[src_idx(sel[1], `LCELL_BASE2)];
		d[2] = data_in[src_idx(sel[2], `LCELL_BASE3)];
		d[3] = data_in[src_idx(sel[3], `LCELL_BASE4)];
		osc_keep_request = 1'b0;
		for (int k = 0; k < 4; k++) begin
			g[k] = gate_fn(gsel[k], d, gate_invert[k]);
		end
		idx = src_idx(sel[2], `LCELL_BASE3);
		if (idx == `LCELL_HFOSC_IDX) begin
			osc_keep_request = ctrl.cell_on_bit;
		end
		idx = src_idx(sel[3], `LCELL_BASE4);
		if (idx == `LCELL_HFOSC_IDX) begin
			osc_keep_request = ctrl.cell_on_bit;
		end
	end

	// logic function: g[0] clock/enable, g[1] data/J, g[2] reset,
	// g[3] set or second data/K; in SR mode g[0]/g[1] set and g[2]/g[3] reset
	always_comb begin
		clk_rise = g[0] && !clk_prev;
		next_q   = q;
		func     = 1'b0;
		case (ctrl.function_select)
			LCELL_AND_OR: func = (g[0] & g[1]) | (g[2] & g[3]);
			LCELL_OR_XOR: func = (g[0] | g[1]) ^ (g[2] | g[3]);
			LCELL_AND4:   func = &g;
			LCELL_SR: begin
				if (g[2] | g[3]) begin
					next_q = 1'b0;
				end else if (g[0] | g[1]) begin
					next_q = 1'b1;
				end
				func = next_q;
			end
			LCELL_DFF_SR: begin
				if (g[2]) begin
					next_q = 1'b0;
				end else if (g[3]) begin
					next_q = 1'b1;
				end else if (clk_rise) begin
					next_q = g[1];
				end
				func = next_q;
			end
			LCELL_DFF_R: begin
				if (g[2]) begin
					next_q = 1'b0;
				end else if (clk_rise) begin
					next_q = g[1] & g[3];
				end
				func = next_q;
			end
			LCELL_JK_R: begin
				if (g[2]) begin
					next_q = 1'b0;
				end else if (clk_rise) begin
					case ({g[1], g[3]})
						2'b10:   next_q = 1'b1;
						2'b01:   next_q = 1'b0;
						2'b11:   next_q = ~q;
						default: next_q = q;
					endcase
				end
				func = next_q;
			end
			LCELL_DLAT: begin
				if (g[2]) begin
					next_q = 1'b0;
				end else if (g[3]) begin
					next_q = 1'b1;
				end else if (g[0]) begin
					next_q = g[1];
				end
				func = next_q;
			end
			default: func = 1'b0;
		endcase
		next_out = ctrl.cell_on_bit & (func ^ final_output_invert);
		rise_evt = next_out & ~cell_out;
		fall_evt = ~next_out & cell_out;
		flag_clr = wr && dp.addr == `LCELL_OFF_FLAG &&
			hwdata[`LCELL_FLAG_BIT];
		next_flag = cell_irq_flag & ~flag_clr;
		// set wins over a clear in the same cycle
		if ((rise_evt && ctrl.rise_irq_enable) ||
			(fall_evt && ctrl.fall_irq_enable)) begin
			next_flag = 1'b1;
		end
	end

	// cell state runs every cycle whatever the cpu does
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q             <= 1'b0;
			clk_prev      <= 1'b0;
			cell_out      <= 1'b0;
			cell_irq_flag <= 1'b0;
		end else begin
			q             <= next_q;
			clk_prev      <= g[0];
			cell_out      <= next_out;
			cell_irq_flag <= next_flag;
		end
	end

	assign pin_out = cell_out & ctrl.pin_drive_enable;
	assign pin_oe  = ctrl.pin_drive_enable;

	// read mux; mirror uses one registered sample of all cells
	always_comb begin
		mirror = 8'h00;
		for (int c = 0; c < CELLS; c++) begin
			mirror[c] = (c == CELL_IDX) ? cell_out : peer_outputs[c];
		end
		hrdata = 32'h0000_0000;
		if (dp.valid && !dp.write) begin
			case (dp.addr)
				`LCELL_OFF_CTRL: begin
					hrdata[7:0] = ctrl;
					hrdata[`LCELL_RB_BIT] = cell_out;
				end
				`LCELL_OFF_POL: begin
					hrdata[`LCELL_FINV_BIT] = final_output_invert;
					hrdata[3:0] = gate_invert;
				end
				`LCELL_OFF_SEL0: hrdata[7:0] = {1'b0, sel[1], 1'b0, sel[0]};
				`LCELL_OFF_SEL1: hrdata[7:0] = {1'b0, sel[3], 1'b0, sel[2]};
				`LCELL_OFF_GATE1:  hrdata[7:0] = gsel[0];
				`LCELL_OFF_GATE2:  hrdata[7:0] = gsel[1];
				`LCELL_OFF_GATE3:  hrdata[7:0] = gsel[2];
				`LCELL_OFF_GATE4:  hrdata[7:0] = gsel[3];
				`LCELL_OFF_MIRROR: hrdata[7:0] = mirror;
				`LCELL_OFF_FLAG: hrdata[`LCELL_FLAG_BIT] = cell_irq_flag;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	AST_RISE_SETS: assert property (@(posedge ref_clk) disable iff (!resetn)
		rise_evt && ctrl.rise_irq_enable |=> cell_irq_flag)
		else $error("enabled rising edge did not set flag");
	AST_FALL_SETS: assert property (@(posedge ref_clk) disable iff (!resetn)
		fall_evt && ctrl.fall_irq_enable |=> cell_irq_flag)
		else $error("enabled falling edge did not set flag");
	AST_FLAG_CAUSE: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(cell_irq_flag) |->
		$past(rise_evt && ctrl.rise_irq_enable ||
		fall_evt && ctrl.fall_irq_enable))
		else $error("flag set without an enabled edge");
	AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!resetn)
		flag_clr && rise_evt && ctrl.rise_irq_enable |=>
		cell_irq_flag)
		else $error("edge lost during flag clear");
	AST_OFF_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
		!ctrl.cell_on_bit ##1 !ctrl.cell_on_bit |-> !cell_out)
		else $error("disabled cell output not zero");
	AST_READBACK: assert property (@(posedge ref_clk) disable iff (!resetn)
		dp.valid && !dp.write && dp.addr == `LCELL_OFF_CTRL |->
		hrdata[`LCELL_RB_BIT] == cell_out)
		else $error("readback bit differs from output");
	AST_MIRROR: assert property (@(posedge ref_clk) disable iff (!resetn)
		dp.valid && !dp.write && dp.addr == `LCELL_OFF_MIRROR |->
		hrdata[CELL_IDX] == cell_out && hrdata[31:8] == 24'h000000)
		else $error("mirror bit differs from output");
	AST_POL_RSVD: assert property (@(posedge ref_clk) disable iff (!resetn)
		dp.valid && !dp.write && dp.addr == `LCELL_OFF_POL |->
		hrdata[6:4] == 3'h0)
		else $error("reserved polarity bits not zero");
	AST_CTRL_RESET: assert property (@(posedge ref_clk)
		!resetn |=> ctrl == lcell_ctrl_t'(`LCELL_CTRL_RST) && !cell_out)
		else $error("control not cleared by reset");
	AST_PIN: assert property (@(posedge ref_clk) disable iff (!resetn)
		!pin_oe |-> !pin_out)
		else $error("pin driven while disconnected");
	AST_FINV: assert property (@(posedge ref_clk) disable iff (!resetn)
		ctrl.cell_on_bit && $stable(ctrl) && q == $past(q) &&
		$stable(g) && $changed(final_output_invert) |=>
		cell_out != $past(cell_out))
		else $error("final invert did not flip output");
endmodule // lcell_core

/* lcell_src.sv */
`timescale 1ns/1ps
module lcell_src (
	input  wire logic        ref_clk,
	input  wire logic [15:0] pat,
	input  wire logic [1:0]  peer_pat,
	output logic      [15:0] data_in,
	output logic      [1:0]  peer_outputs
);
	// sources move only at the clock edge, like synchronous peripherals
	always_ff @(posedge ref_clk) begin
		data_in      <= pat;
		peer_outputs <= peer_pat;
	end
endmodule // lcell_src

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        ref_clk, resetn, hsel, hwrite, rdy_q;
	logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
	logic [1:0]  htrans, peer_pat, peer_outputs;
	logic [2:0]  hsize;
	logic [15:0] pat, data_in;
	logic        hreadyout, hresp, cell_out, pin_out, pin_oe;
	logic        cell_irq_flag, osc_keep_request;
	int          n_checks, bad_count;
	// {mode, gate inputs 4..1, expected output} per step
	localparam logic [7:0] SQ [23] = '{8'h63, 8'h61, 8'h68, 8'h60,
		8'h91, 8'h88, 8'h87, 8'h85, 8'hA8, 8'hB4, 8'hB7, 8'hA7, 8'hA5,
		8'hA6, 8'hC8, 8'hC4, 8'hC7, 8'hD1, 8'hD2, 8'hE7, 8'hE2, 8'hE0,
		8'hF1};
	lcell_core #(.CELLS(2), .CELL_IDX(0)) u_lcell_core (.ref_clk, .resetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .data_in, .peer_outputs,
		.cell_out, .pin_out, .pin_oe, .cell_irq_flag, .osc_keep_request);
	lcell_src u_lcell_src (.ref_clk, .pat, .peer_pat, .data_in,
		.peer_outputs);
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	always_ff @(posedge ref_clk) begin
		rd_q  <= hrdata;
		rdy_q <= hreadyout;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] wd);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do cyc(1); while (rdy_q !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do cyc(1); while (rdy_q !== 1'h1);
		rd = rd_q;
	endtask
	task automatic wr(input logic [7:0] a, d);
		bus(1'h1, a, {24'h0, d});
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, e);
		bus(1'h0, a, 32'h0);
		chk(nm, rd, {24'h0, e});
	endtask
	task automatic gates(input logic [31:0] g);
		for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), g[8*i+:8]);
	endtask
	function automatic logic [15:0] spread(input logic [3:0] v);
		return {3'h0, v[3], 3'h0, v[2], 3'h0, v[1], 3'h0, v[0]};
	endfunction
	function automatic logic fexp(input logic [2:0] m,
			input logic [3:0] v, input logic [7:0] p);
		logic [3:0] g;
		logic       r;
		g = v ^ p[3:0];
		case (m)
			3'h0: r = (g[0] & g[1]) | (g[2] & g[3]);
			3'h1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
			default: r = &g;
		endcase
		return r ^ p[7];
	endfunction
	task automatic t_reset();
		rdc("ctrl", 8'h00, 8'h00);
		chk("out", cell_out, 32'h0);
		chk("flag", cell_irq_flag, 32'h0);
		chk("resp", hresp, 32'h0);
		rdc("unmapped", 8'h30, 8'h00);
		wr(8'h04, 8'hFF);
		rdc("pol", 8'h04, 8'h8F);
		$display("done reset");
	endtask
	task automatic t_comb();
		logic [7:0] p;
		logic       e;
		wr(8'h08, 8'h00);
		wr(8'h0C, 8'h00);
		gates(32'h40100401);
		for (int k = 0; k < 2; k++) begin
			p = k ? 8'h85 : 8'h00;
			wr(8'h04, p);
			for (int m = 0; m < 3; m++) begin
				wr(8'h00, 8'hA0 | 8'(m));
				for (int v = 0; v < 16; v++) begin
					pat <= spread(4'(v));
					cyc(3);
					e = fexp(3'(m), 4'(v), p);
					chk("out", cell_out, {31'h0, e});
					rdc("rdbk", 8'h00, 8'h80 | 8'(m) | {2'h0, e, 5'h0});
				end
			end
		end
		$display("done comb");
	endtask
	task automatic t_seq();
		wr(8'h04, 8'h00);
		for (int i = 0; i < 23; i++) begin
			wr(8'h00, {5'h10, SQ[i][7:5]});
			pat <= spread(SQ[i][4:1]);
			cyc(3);
			chk("seq", cell_out, {31'h0, SQ[i][0]});
		end
		$display("done seq");
	endtask
	task automatic t_gate();
		gates(32'h000000AA);
		wr(8'h04, 8'h0E);
		wr(8'h00, 8'h82);
		pat <= spread(4'h0);
		cyc(3);
		chk("nor", cell_out, 32'h1);
		pat <= spread(4'h4);
		cyc(3);
		chk("nor", cell_out, 32'h0);
		$display("done gate");
	endtask
	task automatic t_irq();
		gates(32'h00000001);
		wr(8'h04, 8'h0E);
		pat <= 16'h0;
		wr(8'h00, 8'h92);
		wr(8'h24, 8'h01);
		pat <= spread(4'h1);
		cyc(3);
		chk("out", cell_out, 32'h1);
		chk("flag", cell_irq_flag, 32'h1);
		wr(8'h24, 8'h01);
		rdc("flag", 8'h24, 8'h00);
		pat <= 16'h0;
		cyc(3);
		chk("flag", cell_irq_flag, 32'h0);
		// rising edge lands in the data phase of the clearing write
		pat <= spread(4'h1);
		wr(8'h24, 8'h01);
		cyc(1);
		chk("flag", cell_irq_flag, 32'h1);
		pat <= 16'h0;
		cyc(3);
		wr(8'h24, 8'h01);
		wr(8'h00, 8'h8A);
		pat <= spread(4'h1);
		cyc(3);
		chk("flag", cell_irq_flag, 32'h0);
		pat <= 16'h0;
		cyc(3);
		chk("flag", cell_irq_flag, 32'h1);
		wr(8'h24, 8'h01);
		wr(8'h00, 8'h9A);
		wr(8'h04, 8'h8E);
		cyc(2);
		chk("flag", cell_irq_flag, 32'h1);
		wr(8'h24, 8'h01);
		wr(8'h00, 8'hCA);
		cyc(2);
		chk("oe", pin_oe, 32'h1);
		chk("pin", pin_out, 32'h1);
		peer_pat <= 2'h2;
		cyc(3);
		rdc("mirror", 8'h20, 8'h03);
		peer_pat <= 2'h0;
		cyc(3);
		rdc("mirror", 8'h20, 8'h01);
		wr(8'h00, 8'h0A);
		cyc(2);
		chk("out", cell_out, 32'h0);
		chk("oe", pin_oe, 32'h0);
		chk("pin", pin_out, 32'h0);
		chk("flag", cell_irq_flag, 32'h1);
		$display("done irq");
	endtask
	task automatic t_osc();
		wr(8'h0C, 8'h05);
		wr(8'h00, 8'h82);
		chk("osc", osc_keep_request, 32'h1);
		wr(8'h00, 8'h02);
		chk("osc", osc_keep_request, 32'h0);
		wr(8'h0C, 8'h10);
		wr(8'h00, 8'h82);
		chk("osc4", osc_keep_request, 32'h1);
		wr(8'h0C, 8'h00);
		chk("osc", osc_keep_request, 32'h0);
		$display("done osc");
	endtask
	task automatic t_rst();
		wr(8'h00, 8'h82);
		resetn <= 1'h0;
		cyc(2);
		resetn <= 1'h1;
		cyc(1);
		rdc("ctrl", 8'h00, 8'h00);
		rdc("pol", 8'h04, 8'h0E);
		wr(8'h00, 8'h82);
		pat <= spread(4'h1);
		cyc(3);
		chk("out", cell_out, 32'h1);
		pat <= 16'h0;
		cyc(3);
		chk("out", cell_out, 32'h0);
		$display("done midreset");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		end_sim();
	end
	initial begin
		resetn   = 1'h0;
		hsel     = 1'h0;
		htrans   = 2'h0;
		haddr    = 32'h0;
		hwrite   = 1'h0;
		hsize    = 3'h2;
		hwdata   = 32'h0;
		pat      = 16'h0;
		peer_pat = 2'h0;
		cyc(5);
		resetn <= 1'h1;
		cyc(1);
		t_reset();
		t_comb();
		t_seq();
		t_gate();
		t_irq();
		t_osc();
		t_rst();
		end_sim();
	end
endmodule // testbench
